// file: pll_div_pkg.sv
/*
  Constants, field layout and carrier types for the divider serial loader.
  Assumes a single 200 MHz system clock and link pins sampled synchronously.
*/
package pll_div_pkg;

  // Clock rate
  localparam int CLK_MHZ = 200;

  // Shift register and word layout
  localparam int SHIFT_W = 19;
  localparam int SEL_POS = 0;
  localparam int REF_LSB = 1;
  localparam int REF_W = 14;
  localparam int PSC_POS = 15;
  localparam int SWAL_LSB = 1;
  localparam int SWAL_W = 7;
  localparam int MAIN_LSB = 8;
  localparam int MAIN_W = 11;
  localparam int PRE_W = 8;

  // Latch and shift register reset values
  localparam logic [13:0] REF_RST = 14'h0003;
  localparam logic PSC_RST = 1'b0;
  localparam logic [6:0] SWAL_RST = 7'h00;
  localparam logic [10:0] MAIN_RST = 11'h003;
  localparam logic [18:0] SHIFT_RST = 19'h00000;

  // Prescaler last count: modulus minus one
  localparam logic [7:0] PRE_LAST_128 = 8'h7F;
  localparam logic [7:0] PRE_LAST_64 = 8'h3F;

  // Serial link pins
  typedef struct packed {
    logic ser_clk;
    logic ser_data;
    logic load_strobe;
  } serial_link_t;

  // Reference word latch
  typedef struct packed {
    logic prescaler_modulus_bit;
    logic [13:0] ratio;
  } ref_latch_t;

  // Frequency word latch
  typedef struct packed {
    logic [10:0] main_ratio;
    logic [6:0] swallow_ratio;
  } fb_latch_t;

endpackage : pll_div_pkg

// file: pll_divider_serial_loader.sv
/*
  Serial word loader, reference divider and dual-modulus feedback divider.
  Assumes link pins, reference and VCO inputs are synchronous to clk_i and
  each input stays at one level for at least one clock between edges.
*/
`timescale 1ns/1ps

module pll_divider_serial_loader (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire pll_div_pkg::serial_link_t serial_i,
  input wire logic ref_in_i,
  input wire logic vco_in_i,
  output pll_div_pkg::ref_latch_t ref_latch_o,
  output pll_div_pkg::fb_latch_t fb_latch_o,
  output logic comp_clk_o,
  output logic fb_clk_o,
  output logic modulus_ctrl_o
);
  import pll_div_pkg::*;

  // Layout checks on package constants
  if (SEL_POS != 0 || REF_LSB != SEL_POS + 1 || SWAL_LSB != SEL_POS + 1) begin : g_sel_chk
    $error("select bit must sit just below the data fields");
  end
  if (PSC_POS != REF_LSB + REF_W) begin : g_psc_chk
    $error("modulus bit must sit above the reference ratio");
  end
  if (MAIN_LSB != SWAL_LSB + SWAL_W || MAIN_LSB + MAIN_W != SHIFT_W) begin : g_fb_chk
    $error("swallow and main fields must fill the shift register");
  end
  if (PRE_W < 8) begin : g_pre_chk
    $error("prescaler counter too narrow for modulus 129");
  end

  // Edge detect on link clock and divider inputs
  logic ser_clk_prev_r;
  logic ref_prev_r;
  logic vco_prev_r;
  wire ser_rise = serial_i.ser_clk & ~ser_clk_prev_r;
  wire ref_rise = ref_in_i & ~ref_prev_r;
  wire vco_rise = vco_in_i & ~vco_prev_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ser_clk_prev_r <= 1'b0;
      ref_prev_r <= 1'b0;
      vco_prev_r <= 1'b0;
    end else begin
      ser_clk_prev_r <= serial_i.ser_clk;
      ref_prev_r <= ref_in_i;
      vco_prev_r <= vco_in_i;
    end
  end

  // Shift register
  logic [SHIFT_W-1:0] shift_r;
  wire [SHIFT_W-1:0] shift_nxt = {shift_r[SHIFT_W-2:0], serial_i.ser_data};

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_r <= SHIFT_RST;
    end else if (ser_rise) begin
      shift_r <= shift_nxt;
    end
  end

  // Word decode
  wire word_sel = shift_r[SEL_POS];
  wire load_ref = serial_i.load_strobe & word_sel;
  wire load_fb = serial_i.load_strobe & ~word_sel;
  ref_latch_t ref_word;
  fb_latch_t fb_word;
  assign ref_word.prescaler_modulus_bit = shift_r[PSC_POS];
  assign ref_word.ratio = shift_r[REF_LSB +: REF_W];
  assign fb_word.swallow_ratio = shift_r[SWAL_LSB +: SWAL_W];
  assign fb_word.main_ratio = shift_r[MAIN_LSB +: MAIN_W];

  // Latches, written only while the strobe is high
  ref_latch_t ref_latch_r;
  fb_latch_t fb_latch_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ref_latch_r <= '{prescaler_modulus_bit: PSC_RST, ratio: REF_RST};
    end else if (load_ref) begin
      ref_latch_r <= ref_word;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fb_latch_r <= '{main_ratio: MAIN_RST, swallow_ratio: SWAL_RST};
    end else if (load_fb) begin
      fb_latch_r <= fb_word;
    end
  end

  assign ref_latch_o = ref_latch_r;
  assign fb_latch_o = fb_latch_r;

  // Reference divider
  logic [REF_W-1:0] ref_cnt_r;
  logic comp_clk_r;
  wire ref_wrap = ref_rise & (ref_cnt_r == '0);
  wire [REF_W-1:0] ref_cnt_nxt = ref_wrap ? ref_latch_r.ratio - 14'h0001
                                          : ref_cnt_r - 14'h0001;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ref_cnt_r <= '0;
      comp_clk_r <= 1'b0;
    end else begin
      if (ref_rise) begin
        ref_cnt_r <= ref_cnt_nxt;
      end
      comp_clk_r <= ref_wrap;
    end
  end

  assign comp_clk_o = comp_clk_r;

  // Dual-modulus prescaler
  logic [PRE_W-1:0] pre_cnt_r;
  logic mod_ctrl_r;
  wire [PRE_W-1:0] pre_base = ref_latch_r.prescaler_modulus_bit ? PRE_LAST_64
                                                               : PRE_LAST_128;
  wire [PRE_W-1:0] pre_last = pre_base + {7'h00, mod_ctrl_r};
  wire pre_wrap = vco_rise & (pre_cnt_r == pre_last);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_cnt_r <= '0;
    end else if (vco_rise) begin
      pre_cnt_r <= pre_wrap ? '0 : pre_cnt_r + 8'h01;
    end
  end

  // Main and swallow counters
  logic [MAIN_W-1:0] main_cnt_r;
  logic [SWAL_W-1:0] swal_cnt_r;
  logic fb_clk_r;
  wire fb_end = pre_wrap & (main_cnt_r <= 11'h001);
  wire [MAIN_W-1:0] main_cnt_nxt = fb_end ? fb_latch_r.main_ratio
                                          : main_cnt_r - 11'h001;
  wire [SWAL_W-1:0] swal_dec = (swal_cnt_r != '0) ? swal_cnt_r - 7'h01 : swal_cnt_r;
  wire [SWAL_W-1:0] swal_cnt_nxt = fb_end ? fb_latch_r.swallow_ratio : swal_dec;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      main_cnt_r <= MAIN_RST;
      swal_cnt_r <= SWAL_RST;
      mod_ctrl_r <= 1'b0;
    end else if (pre_wrap) begin
      main_cnt_r <= main_cnt_nxt;
      swal_cnt_r <= swal_cnt_nxt;
      mod_ctrl_r <= (swal_cnt_nxt != '0);
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fb_clk_r <= 1'b0;
    end else begin
      fb_clk_r <= fb_end;
    end
  end

  assign fb_clk_o = fb_clk_r;
  assign modulus_ctrl_o = mod_ctrl_r;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // Independent count of VCO rises per prescaler cycle
  logic [8:0] pre_seen_r;
  logic pre_clean_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pre_seen_r <= '0;
      pre_clean_r <= 1'b1;
    end else begin
      if (pre_wrap) begin
        pre_seen_r <= '0;
      end else if (vco_rise) begin
        pre_seen_r <= pre_seen_r + 9'h001;
      end
      pre_clean_r <= ~load_ref & (pre_wrap | pre_clean_r);
    end
  end

  sequence s_ser_edge;
    ser_rise && !serial_i.load_strobe;
  endsequence

  sequence s_shifted;
    shift_r == {$past(shift_r[SHIFT_W-2:0]), $past(serial_i.ser_data)};
  endsequence

  a_shift_msb_first: assert property (
    s_ser_edge |=> s_shifted)
    else $error("shift register did not take data bit");

  a_ref_load_fields: assert property (
    load_ref |=> ref_latch_o.ratio == $past(shift_r[14:1])
      && ref_latch_o.prescaler_modulus_bit == $past(shift_r[15]))
    else $error("reference latch load wrong");

  a_fb_load_fields: assert property (
    load_fb |=> fb_latch_o.swallow_ratio == $past(shift_r[7:1])
      && fb_latch_o.main_ratio == $past(shift_r[18:8]))
    else $error("frequency latch load wrong");

  a_ref_kept_fb: assert property (
    load_fb |=> $stable(ref_latch_o))
    else $error("reference latch changed on frequency load");

  a_latch_hold_idle: assert property (
    !serial_i.load_strobe |=> $stable(ref_latch_o) && $stable(fb_latch_o))
    else $error("latch changed without strobe");

  a_prescale_modulus: assert property (
    pre_wrap |-> pre_cnt_r == (ref_latch_r.prescaler_modulus_bit ? 8'h3F : 8'h7F)
      + {7'h00, modulus_ctrl_o})
    else $error("prescaler modulus wrong");

  a_swallow_phase: assert property (
    pre_wrap && !fb_end |=> modulus_ctrl_o == ($past(swal_cnt_r) > 7'h01))
    else $error("modulus control not tied to swallow count");

  sequence s_ref_reload;
    ##1 (comp_clk_o && ref_cnt_r == $past(ref_latch_r.ratio) - 14'h0001);
  endsequence

  a_ref_divide: assert property (
    ref_wrap |-> s_ref_reload)
    else $error("reference divider reload wrong");

  a_fb_period: assert property (
    pre_wrap && main_cnt_r == 11'h001 |=> fb_clk_o
      && main_cnt_r == $past(fb_latch_r.main_ratio)
      && swal_cnt_r == $past(fb_latch_r.swallow_ratio))
    else $error("feedback divider reload wrong");

  a_fb_pulse_only: assert property (
    fb_clk_o |-> $past(pre_wrap) && $past(main_cnt_r) <= 11'h001)
    else $error("feedback pulse without end of count");

  a_shift_idle_hold: assert property (
    !ser_rise |=> $stable(shift_r))
    else $error("shift register moved without a link clock rise");

  a_fb_kept_ref: assert property (
    load_ref |=> $stable(fb_latch_o))
    else $error("frequency latch changed on reference load");

  a_comp_pulse_only: assert property (
    comp_clk_o |-> $past(ref_wrap))
    else $error("compare pulse without reference wrap");

  a_ref_count_step: assert property (
    ref_rise && !ref_wrap |=> ref_cnt_r == $past(ref_cnt_r) - 14'h0001)
    else $error("reference count did not step down");

  a_ref_count_hold: assert property (
    !ref_rise |=> $stable(ref_cnt_r))
    else $error("reference count moved without input rise");

  a_pre_count_step: assert property (
    vco_rise && !pre_wrap |=> pre_cnt_r == $past(pre_cnt_r) + 8'h01)
    else $error("prescaler count did not step up");

  a_prescale_length: assert property (
    pre_wrap && pre_clean_r |-> pre_seen_r
      == (ref_latch_r.prescaler_modulus_bit ? 9'h03F : 9'h07F) + {8'h00, modulus_ctrl_o})
    else $error("prescaler cycle length wrong");

  a_fb_count_hold: assert property (
    !pre_wrap |=> $stable(main_cnt_r) && $stable(swal_cnt_r) && $stable(modulus_ctrl_o))
    else $error("feedback counters moved between prescaler wraps");

  a_main_count_step: assert property (
    pre_wrap && !fb_end |=> main_cnt_r == $past(main_cnt_r) - 11'h001)
    else $error("main count did not step down");

  a_modulus_reload: assert property (
    fb_end |=> modulus_ctrl_o == ($past(fb_latch_r.swallow_ratio) != 7'h00))
    else $error("modulus control wrong after reload");

endmodule : pll_divider_serial_loader

// file: pll_host_model.sv
/*
  Host side of the three-wire programming link.
  Assumes the loader samples the link pins on the rising edge of clk_i.
*/
`timescale 1ns/1ps
module pll_host_model (
  input wire logic clk_i,
  output pll_div_pkg::serial_link_t serial_o
);
  import pll_div_pkg::*;
  initial serial_o = '0;
  // Sends the low n bits of w, then an optional strobe
  task automatic send(input logic [18:0] w, input int n, input logic ld);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk_i) serial_o.ser_data <= w[i];
      @(posedge clk_i) serial_o.ser_clk <= 1'b1;
      @(posedge clk_i) begin
        serial_o.ser_clk <= 1'b0;
        if (i == 0) serial_o.ser_data <= ~w[0];
      end
    end
    if (ld) begin
      @(posedge clk_i) serial_o.load_strobe <= 1'b1;
      @(posedge clk_i) serial_o.load_strobe <= 1'b0;
    end
  endtask : send
endmodule : pll_host_model

// file: testbench.sv
/*
  Self-checking bench for the divider serial loader.
  Assumes the host model drives the link and ref/vco toggle each clock.
*/
`timescale 1ns/1ps
module testbench;
  import pll_div_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ref_in_i = 1'b0;
  logic vco_in_i = 1'b0;
  serial_link_t serial_i;
  ref_latch_t ref_latch_o;
  fb_latch_t fb_latch_o;
  logic comp_clk_o, fb_clk_o, modulus_ctrl_o;
  int err_count = 0;
  int checked = 0;
  bit timed_out = 1'b0;
  logic [32:0] notes[$];
  logic [32:0] exp_v, last_v;
  logic [13:0] r;
  logic [6:0] s;
  logic [10:0] mn;
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    ref_in_i <= ~ref_in_i;
    vco_in_i <= ~vco_in_i;
  end
  pll_host_model host_u (.clk_i(clk_i), .serial_o(serial_i));
  pll_divider_serial_loader dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .serial_i(serial_i), .ref_in_i(ref_in_i), .vco_in_i(vco_in_i),
    .ref_latch_o(ref_latch_o), .fb_latch_o(fb_latch_o), .comp_clk_o(comp_clk_o),
    .fb_clk_o(fb_clk_o), .modulus_ctrl_o(modulus_ctrl_o));
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    if (err_count == 0 && checked > 0 && notes.size() == 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  // Notes the expected latch pair, then sends the word with a strobe
  task automatic load(input logic [18:0] w, input int n);
    logic [32:0] nxt;
    nxt = exp_v;
    if (w[0]) nxt[32:18] = w[15:1];
    else nxt[17:0] = w[18:1];
    if (nxt !== exp_v) notes.push_back(nxt);
    exp_v = nxt;
    host_u.send(w, n, 1'b1);
  endtask : load
  // Latch watcher: every change must match the oldest note
  always @(negedge clk_i) begin
    if ({ref_latch_o, fb_latch_o} !== last_v) begin
      last_v = {ref_latch_o, fb_latch_o};
      if (notes.size() > 0) begin
        check("latches", last_v, notes.pop_front());
      end else begin
        check("unexpected latch change", last_v, exp_v ^ 33'h1FFFFFFFF);
      end
    end
  end
  // Measures the third pulse interval and the modulus-high time in it
  task automatic period(input bit fb, input int exp_c, input int exp_h);
    int c, h;
    if (timed_out) return;
    for (int n = 0; n < 3; n++) begin
      c = 0;
      h = 0;
      do begin
        @(negedge clk_i);
        c++;
        if (modulus_ctrl_o === 1'b1) h++;
      end while ((fb ? fb_clk_o : comp_clk_o) !== 1'b1 && c < 20000);
      if (c >= 20000) begin
        check("pulse timeout", 33'h0, 33'h1);
        timed_out = 1'b1;
        return;
      end
    end
    check(fb ? "feedback period" : "compare period", 33'(c), 33'(exp_c));
    if (fb) check("modulus high time", 33'(h), 33'(exp_h));
  endtask : period
  initial begin
    void'($urandom(105));
    exp_v = {PSC_RST, REF_RST, MAIN_RST, SWAL_RST};
    last_v = exp_v;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    check("reset latches", {ref_latch_o, fb_latch_o}, exp_v);
    load({3'h0, 1'b0, 14'd400, 1'b1}, 16);
    load({11'd214, 7'd108, 1'b0}, 19);
    r = 14'($urandom_range(16383, 3));
    load({3'h0, 1'b1, r, 1'b1}, 16);
    s = 7'($urandom_range(127, 0));
    mn = 11'($urandom_range(2047, (s < 3) ? 3 : s));
    load({mn, s, 1'b0}, 19);
    host_u.send(19'($urandom), 19, 1'b0);
    repeat (4) @(posedge clk_i);
    for (int m = 0; m < 2; m++) begin
      load({3'h0, m[0], 14'd5, 1'b1}, 16);
      load({11'd4, 7'd3, 1'b0}, 19);
      period(1'b0, 2 * 5, 0);
      period(1'b1, 2 * ((m[0] ? 64 : 128) * 4 + 3), 2 * 3 * ((m[0] ? 64 : 128) + 1));
    end
    print_verdict();
  end
endmodule : testbench
